/* shared/cdoalu_pkg.sv */
// Package: opcodes, widths and condition code layout for the ALU datapath
package cdoalu_pkg;

  // --------------------
  // Widths
  // --------------------
  localparam int unsigned CDOALU_W = 16;
  localparam int unsigned CDOALU_DW = 32;
  localparam int unsigned CDOALU_REGW = 3;
  localparam int unsigned CDOALU_OPW = 7;

  // --------------------
  // Operation codes (octal)
  // --------------------
  localparam logic [6:0] CDOALU_OP_COPY_W = 7'o001;
  localparam logic [6:0] CDOALU_OP_CMP_W = 7'o002;
  localparam logic [6:0] CDOALU_OP_TEST_W = 7'o003;
  localparam logic [6:0] CDOALU_OP_CLR_W = 7'o004;
  localparam logic [6:0] CDOALU_OP_SET_W = 7'o005;
  localparam logic [6:0] CDOALU_OP_ADD_W = 7'o006;
  localparam logic [6:0] CDOALU_OP_COPY_B = 7'o011;
  localparam logic [6:0] CDOALU_OP_CMP_B = 7'o012;
  localparam logic [6:0] CDOALU_OP_TEST_B = 7'o013;
  localparam logic [6:0] CDOALU_OP_CLR_B = 7'o014;
  localparam logic [6:0] CDOALU_OP_SET_B = 7'o015;
  localparam logic [6:0] CDOALU_OP_SUB_W = 7'o016;
  localparam logic [6:0] CDOALU_OP_MUL = 7'o070;
  localparam logic [6:0] CDOALU_OP_DIV = 7'o071;
  localparam logic [6:0] CDOALU_OP_SHIFT = 7'o072;
  localparam logic [6:0] CDOALU_OP_SHIFT2 = 7'o073;
  localparam logic [6:0] CDOALU_OP_XOR = 7'o074;

  // --------------------
  // Condition code bit positions and reset values
  // --------------------
  localparam int unsigned CDOALU_CC_N = 3;
  localparam int unsigned CDOALU_CC_Z = 2;
  localparam int unsigned CDOALU_CC_V = 1;
  localparam int unsigned CDOALU_CC_C = 0;
  localparam logic [3:0] CDOALU_CC_RST = 4'h0;
  localparam logic [15:0] CDOALU_WORD_RST = 16'h0000;

  // --------------------
  // Divider timing: one quotient bit per cycle
  // --------------------
  localparam logic [5:0] CDOALU_DIV_STEPS = 6'h20;

  // Controller states
  typedef enum logic [2:0] {
    CDOALU_IDLE = 3'b001,
    CDOALU_DIVW = 3'b010,
    CDOALU_DONE = 3'b100
  } cdoalu_state_t;

endpackage : cdoalu_pkg

/* tb/cdoalu_chk.sv */
// Concurrent checks on the ALU datapath ports
`timescale 1ns/1ps
module cdoalu_chk (
  // Clock, reset and request
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [6:0] op_in,
  input wire logic [2:0] reg_idx_in,
  input wire logic [15:0] src_in,
  input wire logic [15:0] dst_in,
  input wire logic [15:0] reg_val_in,
  input wire logic [3:0] cc_in,
  // Answer
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic wr_dst_out,
  input wire logic [15:0] dst_res_out,
  input wire logic wr_reg_out,
  input wire logic [15:0] reg_res_out,
  input wire logic wr_pair_out,
  input wire logic [15:0] pair_res_out,
  input wire logic [3:0] cc_out
);
  import cdoalu_pkg::*;
  logic tk, tk_q, dn_q;
  logic [6:0] op_q;
  logic [2:0] i_q;
  logic [15:0] s_q, d_q, r_q;
  logic [3:0] c_q;
  logic [16:0] sum;
  logic signed [31:0] prod;
  // A start right after any done may be ignored, so skip it
  assign tk = start_in && !busy_out && !done_out && !dn_q;
  assign sum = {1'b0, d_q} + {1'b0, s_q};
  assign prod = $signed(r_q) * $signed(s_q);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tk_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      tk_q <= tk;
      dn_q <= done_out;
    end
  end
  // Operands only read while tk_q is high, so no reset needed
  always_ff @(posedge clk_in) begin
    op_q <= op_in;
    i_q <= reg_idx_in;
    s_q <= src_in;
    d_q <= dst_in;
    r_q <= reg_val_in;
    c_q <= cc_in;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  copy_word_a: assert property (
    tk_q && op_q == CDOALU_OP_COPY_W |-> done_out && wr_dst_out &&
    dst_res_out == s_q && cc_out == {s_q[15], s_q == 0, 1'b0, c_q[0]})
    else $error("copy word wrong");
  add_word_a: assert property (
    tk_q && op_q == CDOALU_OP_ADD_W |->
    dst_res_out == sum[15:0] && cc_out[0] == sum[16])
    else $error("add wrong");
  sub_word_a: assert property (
    tk_q && op_q == CDOALU_OP_SUB_W |->
    dst_res_out == d_q - s_q && cc_out[0] == (s_q > d_q))
    else $error("subtract wrong");
  cmp_word_a: assert property (
    tk_q && op_q == CDOALU_OP_CMP_W |-> !wr_dst_out &&
    cc_out[2] == (s_q == d_q) && cc_out[0] == (d_q > s_q))
    else $error("compare wrong");
  test_word_a: assert property (
    tk_q && op_q == CDOALU_OP_TEST_W |-> !wr_dst_out &&
    cc_out[2] == ((s_q & d_q) == 0) && !cc_out[1])
    else $error("bit test wrong");
  mul_even_a: assert property (
    tk_q && op_q == CDOALU_OP_MUL && !i_q[0] |-> wr_reg_out &&
    wr_pair_out && {reg_res_out, pair_res_out} == prod &&
    cc_out[0] == (prod != {{16{prod[15]}}, prod[15:0]}))
    else $error("product wrong");
  div_zero_a: assert property (
    tk_q && op_q == CDOALU_OP_DIV && s_q == 0 |-> done_out &&
    !wr_reg_out && !wr_pair_out && cc_out[1:0] == 2'b11)
    else $error("zero divisor wrong");
  div_time_a: assert property (
    tk && op_in == CDOALU_OP_DIV && src_in != 0 |=>
    busy_out [*8] ##[20:30] done_out && wr_reg_out)
    else $error("divide timing wrong");
  shift_zero_a: assert property (
    tk_q && op_q == CDOALU_OP_SHIFT && s_q[5:0] == 0 |->
    reg_res_out == r_q && cc_out[1:0] == 2'b00)
    else $error("zero shift wrong");
  cover property (tk_q && op_q == CDOALU_OP_DIV);
  cover property (tk_q && op_q == CDOALU_OP_MUL);
  cover property (tk_q && op_q == CDOALU_OP_SHIFT2);
endmodule : cdoalu_chk

bind cdoalu_core cdoalu_chk chk_u (.clk_in, .rst_in, .start_in, .op_in,
  .reg_idx_in, .src_in, .dst_in, .reg_val_in, .cc_in, .busy_out,
  .done_out, .wr_dst_out, .dst_res_out, .wr_reg_out, .reg_res_out,
  .wr_pair_out, .pair_res_out, .cc_out);

/* tb/cdoalu_regs_model.sv */
// Register file model standing in for decode and operand fetch
`timescale 1ns/1ps
module cdoalu_regs_model (
  // Clock and operand read
  input wire logic clk_in,
  input wire logic [2:0] sel_in,
  output logic [15:0] sel_val_out,
  output logic [15:0] pair_val_out,
  // Write-back from the datapath
  input wire logic wr_sel_in,
  input wire logic [2:0] sel_idx_in,
  input wire logic [15:0] sel_res_in,
  input wire logic wr_pair_in,
  input wire logic [2:0] pair_idx_in,
  input wire logic [15:0] pair_res_in
);
  logic [15:0] rf [8];
  // Known contents so unused operands never carry unknowns
  initial foreach (rf[i]) rf[i] = 16'h0000;
  // Partner register is the index with bit zero forced
  assign sel_val_out = rf[sel_in];
  assign pair_val_out = rf[sel_in | 3'h1];
  // Partner written last, so an odd index ends with the low half
  always @(posedge clk_in) begin
    if (wr_sel_in) begin
      rf[sel_idx_in] = sel_res_in;
    end
    if (wr_pair_in) begin
      rf[pair_idx_in] = pair_res_in;
    end
  end
  // Preload hook for the bench
  task automatic put(input logic [2:0] i, input logic [15:0] v);
    rf[i] = v;
  endtask : put
endmodule : cdoalu_regs_model

/* tb/tb_compat_double_operand_alu.sv */
// Self-checking testbench for the double-operand ALU datapath
`timescale 1ns/1ps
module tb_compat_double_operand_alu;
  import cdoalu_pkg::*;
  logic clk_in, rst_in, start_in, dst_is_reg_in, bz;
  logic busy_out, done_out, wr_dst_out, wr_reg_out, wr_pair_out;
  logic [6:0] op_in;
  logic [2:0] reg_idx_in, reg_idx_out, pair_idx_out;
  logic [15:0] src_in, dst_in, reg_val_in, pair_val_in;
  logic [15:0] dst_res_out, reg_res_out, pair_res_out;
  logic [3:0] cc_in, cc_out;
  int failures, check_count;
  cdoalu_core dut_u (.clk_in, .rst_in, .start_in, .op_in, .reg_idx_in,
    .dst_is_reg_in, .src_in, .dst_in, .reg_val_in, .pair_val_in, .cc_in,
    .busy_out, .done_out, .wr_dst_out, .dst_res_out, .wr_reg_out,
    .reg_idx_out, .reg_res_out, .wr_pair_out, .pair_idx_out,
    .pair_res_out, .cc_out);
  cdoalu_regs_model pm_u (.clk_in, .sel_in(reg_idx_in),
    .sel_val_out(reg_val_in), .pair_val_out(pair_val_in),
    .wr_sel_in(wr_reg_out), .sel_idx_in(reg_idx_out),
    .sel_res_in(reg_res_out), .wr_pair_in(wr_pair_out),
    .pair_idx_in(pair_idx_out), .pair_res_in(pair_res_out));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cc(string n, logic [3:0] e);
    chk(n, {12'h000, e}, {12'h000, cc_out});
  endtask : cc
  // One request, then wait for done and let write-back land
  task automatic op(logic [6:0] o, logic [2:0] i, logic [15:0] s,
      logic [3:0] c, logic [15:0] d = 16'h0000, logic r = 1'b0);
    int k;
    @(posedge clk_in);
    op_in <= o;
    reg_idx_in <= i;
    src_in <= s;
    dst_in <= d;
    cc_in <= c;
    dst_is_reg_in <= r;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    bz = 1'b0;
    #1;
    for (k = 0; done_out !== 1'b1; k++) begin
      bz |= busy_out === 1'b1;
      if (k == 40) begin
        failures++;
        finish_test();
      end
      @(posedge clk_in);
      #1;
    end
    chk("wdst", {15'h0000, o == CDOALU_OP_XOR || (o < 7'o070 &&
      o[2:0] != 3'h2 && o[2:0] != 3'h3)}, {15'h0000, wr_dst_out});
    @(posedge clk_in);
    #1;
  endtask : op
  task automatic t_copy;
    op(CDOALU_OP_COPY_W, 3'h0, 16'h8000, 4'h3, 16'h1234);
    chk("cpw", 16'h8000, dst_res_out);
    cc("cpwc", 4'h9);
    op(CDOALU_OP_COPY_B, 3'h0, 16'h0080, 4'h2, 16'h1234, 1'b1);
    chk("cpbr", 16'hFF80, dst_res_out);
    cc("cpbrc", 4'h8);
    op(CDOALU_OP_COPY_B, 3'h0, 16'h3400, 4'h0, 16'h1280);
    chk("cpbm", 16'h1200, dst_res_out);
    cc("cpbmc", 4'h4);
  endtask : t_copy
  task automatic t_arith;
    op(CDOALU_OP_ADD_W, 3'h0, 16'h0001, 4'h1, 16'h7FFF);
    cc("addv", 4'hA);
    op(CDOALU_OP_ADD_W, 3'h0, 16'h0001, 4'h0, 16'hFFFF);
    cc("addc", 4'h5);
    op(CDOALU_OP_SUB_W, 3'h0, 16'h0001, 4'h0, 16'h8000);
    chk("subv", 16'h7FFF, dst_res_out);
    cc("subvc", 4'h2);
    op(CDOALU_OP_CMP_W, 3'h0, 16'h8000, 4'h0, 16'h0001);
    cc("cmpw", 4'h2);
    op(CDOALU_OP_CMP_B, 3'h0, 16'hAA80, 4'h1, 16'h5501);
    cc("compare_byte_op", 4'h2);
    op(CDOALU_OP_CMP_B, 3'h0, 16'h0001, 4'h0, 16'h0002);
    cc("cmpbc", 4'h9);
  endtask : t_arith
  task automatic t_logic;
    pm_u.put(3'h5, 16'h00FF);
    op(CDOALU_OP_XOR, 3'h5, 16'h0000, 4'h3, 16'h0F0F);
    chk("xor", 16'h0FF0, dst_res_out);
    cc("xorc", 4'h1);
    op(CDOALU_OP_SET_B, 3'h0, 16'h0000, 4'h3, 16'hAB00);
    cc("setb", 4'h5);
    op(CDOALU_OP_CLR_B, 3'h0, 16'h000F, 4'h3, 16'h12FF);
    chk("clrb", 16'h12F0, dst_res_out);
    cc("clrbc", 4'h9);
    op(CDOALU_OP_TEST_B, 3'h0, 16'h0080, 4'h2, 16'hFF80);
    cc("tstb", 4'h8);
  endtask : t_logic
  task automatic t_mul;
    pm_u.put(3'h2, 16'h0100);
    op(CDOALU_OP_MUL, 3'h2, 16'h0100, 4'h2);
    chk("mulh", 16'h0001, pm_u.rf[2]);
    chk("mull", 16'h0000, pm_u.rf[3]);
    cc("mulc", 4'h1);
    pm_u.put(3'h3, 16'hFFFF);
    op(CDOALU_OP_MUL, 3'h3, 16'h0002, 4'h3);
    chk("mulo", 16'hFFFE, pm_u.rf[3]);
    chk("mulk", 16'h0001, pm_u.rf[2]);
    cc("mulon", 4'h8);
  endtask : t_mul
  task automatic t_div;
    pm_u.put(3'h0, 16'hFFFF);
    pm_u.put(3'h1, 16'hFFF9);
    op(CDOALU_OP_DIV, 3'h0, 16'h0002, 4'h3);
    chk("quo", 16'hFFFD, pm_u.rf[0]);
    chk("rem", 16'hFFFF, pm_u.rf[1]);
    chk("busy", 16'h0001, {15'h0000, bz});
    cc("divc", 4'h8);
    op(CDOALU_OP_DIV, 3'h0, 16'h0000, 4'h0);
    chk("dz", 16'hFFFD, pm_u.rf[0]);
    chk("dzvc", 16'h0003, {14'h0000, cc_out[1:0]});
    pm_u.put(3'h0, 16'h4000);
    op(CDOALU_OP_DIV, 3'h0, 16'h0001, 4'h1);
    chk("dovf", 16'h0002, {14'h0000, cc_out[1:0]});
  endtask : t_div
  task automatic t_shift;
    pm_u.put(3'h4, 16'h4001);
    op(CDOALU_OP_SHIFT, 3'h4, 16'h0001, 4'h0);
    chk("shl", 16'h8002, pm_u.rf[4]);
    cc("shlc", 4'hA);
    op(CDOALU_OP_SHIFT, 3'h4, 16'h003F, 4'h0);
    chk("shr", 16'hC001, pm_u.rf[4]);
    cc("shrc", 4'h8);
    op(CDOALU_OP_SHIFT, 3'h4, 16'hFFC0, 4'h3);
    chk("sh0", 16'hC001, pm_u.rf[4]);
    cc("sh0c", 4'h8);
    op(CDOALU_OP_SHIFT, 3'h4, 16'h0020, 4'h0);
    chk("sh32", 16'hFFFF, pm_u.rf[4]);
    cc("sh32c", 4'h9);
    pm_u.put(3'h2, 16'h8000);
    pm_u.put(3'h3, 16'h0001);
    op(CDOALU_OP_SHIFT2, 3'h2, 16'h003F, 4'h0);
    chk("pshh", 16'hC000, pm_u.rf[2]);
    chk("pshl", 16'h0000, pm_u.rf[3]);
    cc("pshc", 4'h9);
  endtask : t_shift
  // Reset, then each scenario in turn
  initial begin
    rst_in = 1'b1;
    {start_in, op_in, reg_idx_in, dst_is_reg_in} = 12'h000;
    {src_in, dst_in, cc_in} = 36'h0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    cc("rst", 4'h0);
    t_copy();
    t_arith();
    t_logic();
    t_mul();
    t_div();
    t_shift();
    finish_test();
  end
endmodule : tb_compat_double_operand_alu

/* verilog/cdoalu_core.sv */
// Compatibility-mode double-operand execution datapath
`timescale 1ns/1ps

// Contract
// - Copy writes source, sets N Z from it, clears V, keeps C.
// - Byte copy into a register sign-extends bit seven into the top byte.
// - Add stores dst plus src; C is carry out, V signed overflow.
// - Subtract stores dst minus src; C is borrow, V per source sign.
// - Compare forms first minus second, flags only, borrow and overflow.
// - Multiply gives 32-bit product, high half to register, low to partner.
// - Multiply N Z from full product, V clear, C if beyond 16 bits.
// - Multiply naming odd register stores only the low 16 bits there.
// - Divide 32-bit pair; quotient to register, remainder with dividend sign.
// - Zero divisor writes nothing and sets both V and C.
// - Quotient beyond 16 signed bits sets V, C clear, results undefined.
// - Divide with odd or stack register gives undefined results.
// - Exclusive-or stores register xor dst, N Z set, V clear, C kept.
// - Bit set stores dst or src, N Z set, V clear, C kept.
// - Bit clear stores dst and not src, N Z set, V clear, C kept.
// - Bit test ands operands, flags only, V clear, C kept.
// - Shift count is low six source bits, signed, negative means right.
// - Right shift replicates sign, left fills zero, C is last bit out.
// - Left shift sets V if any bit through sign differs from original.
// - Zero count keeps operand, N Z from it, V and C cleared.
// - Paired shift treats register and partner as one 32-bit value.
module cdoalu_core (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Request from decode
  input wire logic start_in,
  input wire logic [cdoalu_pkg::CDOALU_OPW-1:0] op_in,
  input wire logic [cdoalu_pkg::CDOALU_REGW-1:0] reg_idx_in,
  input wire logic dst_is_reg_in,
  input wire logic [cdoalu_pkg::CDOALU_W-1:0] src_in,
  input wire logic [cdoalu_pkg::CDOALU_W-1:0] dst_in,
  input wire logic [cdoalu_pkg::CDOALU_W-1:0] reg_val_in,
  input wire logic [cdoalu_pkg::CDOALU_W-1:0] pair_val_in,
  input wire logic [3:0] cc_in,
  // Answer to write-back
  output logic busy_out,
  output logic done_out,
  output logic wr_dst_out,
  output logic [cdoalu_pkg::CDOALU_W-1:0] dst_res_out,
  output logic wr_reg_out,
  output logic [cdoalu_pkg::CDOALU_REGW-1:0] reg_idx_out,
  output logic [cdoalu_pkg::CDOALU_W-1:0] reg_res_out,
  output logic wr_pair_out,
  output logic [cdoalu_pkg::CDOALU_REGW-1:0] pair_idx_out,
  output logic [cdoalu_pkg::CDOALU_W-1:0] pair_res_out,
  output logic [3:0] cc_out
);
  import cdoalu_pkg::*;

  // --------------------
  // Declarations
  // --------------------
  cdoalu_state_t st_q, st_d;
  logic [6:0] op_q, op_d;
  logic [2:0] idx_q, idx_d;
  logic [3:0] ccin_q, ccin_d;
  logic [15:0] divsr_q, divsr_d;
  logic wr_dst_q, wr_dst_d;
  logic wr_reg_q, wr_reg_d;
  logic wr_pair_q, wr_pair_d;
  logic done_q, done_d;
  logic [15:0] dres_q, dres_d;
  logic [15:0] rres_q, rres_d;
  logic [15:0] pres_q, pres_d;
  logic [2:0] ridx_q, ridx_d;
  logic [2:0] pidx_q, pidx_d;
  logic [3:0] cc_q, cc_d;
  logic [2:0] pidx;
  logic [31:0] pair_word;
  logic [31:0] prod;
  logic [31:0] sh_val;
  logic [31:0] sh_res;
  logic [16:0] sum;
  logic [16:0] diff;
  logic [16:0] cdiff;
  logic byte_op;
  logic sh_c;
  logic sh_v;
  logic sh_pair;
  logic div_start;
  logic div_done;
  logic [31:0] quot;
  logic [31:0] rem;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] r;

  assign pidx = reg_idx_in | 3'h1;
  assign pair_word = {reg_val_in, pair_val_in};
  assign sh_pair = (op_in == CDOALU_OP_SHIFT2);
  assign sh_val = sh_pair ? pair_word : {16'h0000, reg_val_in};
  assign prod = 32'($signed(reg_val_in) * $signed(src_in));
  assign byte_op = op_in[3] && (op_in[6:4] == 3'h0) && (op_in != 7'o016);
  assign div_start = start_in && (st_q == CDOALU_IDLE) &&
                     (op_in == CDOALU_OP_DIV) && (src_in != 16'h0000);

  // --------------------
  // Helper units
  // --------------------
  cdoalu_shift u_shift (
    .val_in(sh_val),
    .count_in(src_in[5:0]),
    .pair_in(sh_pair),
    .res_out(sh_res),
    .carry_out(sh_c),
    .ovf_out(sh_v)
  );

  cdoalu_div u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(div_start),
    .dividend_in(pair_word),
    .divisor_in(src_in),
    .done_out(div_done),
    .quot_out(quot),
    .rem_out(rem)
  );

  // --------------------
  // Next-state and result logic
  // --------------------
  // Single-cycle ops and zero-divisor divide answer the cycle after start; other divides wait on the divider
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    idx_d = idx_q;
    ccin_d = ccin_q;
    divsr_d = divsr_q;
    done_d = 1'b0;
    wr_dst_d = 1'b0;
    wr_reg_d = 1'b0;
    wr_pair_d = 1'b0;
    dres_d = dres_q;
    rres_d = rres_q;
    pres_d = pres_q;
    ridx_d = ridx_q;
    pidx_d = pidx_q;
    cc_d = cc_q;
    a = 16'h0000;
    b = 16'h0000;
    r = 16'h0000;
    sum = 17'h0;
    diff = 17'h0;
    cdiff = 17'h0;
    unique case (st_q)
      CDOALU_IDLE: begin
        if (start_in) begin
          ridx_d = reg_idx_in;
          pidx_d = pidx;
          // Byte operands take the low byte, sign at bit seven
          a = byte_op ? {8'h00, src_in[7:0]} : src_in;
          b = byte_op ? {8'h00, dst_in[7:0]} : dst_in;
          sum = {1'b0, b} + {1'b0, a};
          diff = {1'b0, b} - {1'b0, a};
          cdiff = {1'b0, a} - {1'b0, b};
          done_d = 1'b1;
          cc_d = cc_in;
          cc_d[CDOALU_CC_V] = 1'b0;
          unique case (op_in)
            CDOALU_OP_COPY_W, CDOALU_OP_COPY_B: begin
              r = a;
              wr_dst_d = 1'b1;
              dres_d = r;
              if (byte_op && dst_is_reg_in) begin
                dres_d = {{8{src_in[7]}}, src_in[7:0]};
              end else if (byte_op) begin
                dres_d = {dst_in[15:8], src_in[7:0]};
              end
            end
            CDOALU_OP_ADD_W: begin
              r = sum[15:0];
              wr_dst_d = 1'b1;
              dres_d = r;
              cc_d[CDOALU_CC_C] = sum[16];
              cc_d[CDOALU_CC_V] = (a[15] == b[15]) && (r[15] != a[15]);
            end
            CDOALU_OP_SUB_W: begin
              r = diff[15:0];
              wr_dst_d = 1'b1;
              dres_d = r;
              cc_d[CDOALU_CC_C] = diff[16];
              cc_d[CDOALU_CC_V] = (a[15] != b[15]) && (r[15] == a[15]);
            end
            CDOALU_OP_CMP_W, CDOALU_OP_CMP_B: begin
              // First operand arrives on src_in, second on dst_in
              r = byte_op ? {8'h00, cdiff[7:0]} : cdiff[15:0];
              cc_d[CDOALU_CC_C] = byte_op ? cdiff[8] : cdiff[16];
              cc_d[CDOALU_CC_V] = byte_op ?
                ((a[7] != b[7]) && (r[7] == b[7])) :
                ((a[15] != b[15]) && (r[15] == b[15]));
            end
            CDOALU_OP_SET_W, CDOALU_OP_SET_B: begin
              r = b | a;
              wr_dst_d = 1'b1;
              dres_d = byte_op ? {dst_in[15:8], r[7:0]} : r;
            end
            CDOALU_OP_CLR_W, CDOALU_OP_CLR_B: begin
              r = b & ~a;
              wr_dst_d = 1'b1;
              dres_d = byte_op ? {dst_in[15:8], r[7:0]} : r;
            end
            CDOALU_OP_TEST_W, CDOALU_OP_TEST_B: begin
              r = b & a;
            end
            CDOALU_OP_XOR: begin
              r = reg_val_in ^ dst_in;
              wr_dst_d = 1'b1;
              dres_d = r;
            end
            CDOALU_OP_MUL: begin
              // Odd index: pair index equals it, so the low half lands there
              wr_reg_d = !reg_idx_in[0];
              rres_d = prod[31:16];
              wr_pair_d = 1'b1;
              pres_d = prod[15:0];
              cc_d[CDOALU_CC_N] = prod[31];
              cc_d[CDOALU_CC_Z] = (prod == 32'h0);
              cc_d[CDOALU_CC_C] = (prod[31:15] != {17{prod[31]}});
            end
            CDOALU_OP_SHIFT, CDOALU_OP_SHIFT2: begin
              wr_reg_d = 1'b1;
              rres_d = sh_pair ? sh_res[31:16] : sh_res[15:0];
              wr_pair_d = sh_pair;
              pres_d = sh_res[15:0];
              cc_d[CDOALU_CC_N] = sh_pair ? sh_res[31] : sh_res[15];
              cc_d[CDOALU_CC_Z] = sh_pair ? (sh_res == 32'h0) :
                                  (sh_res[15:0] == 16'h0000);
              cc_d[CDOALU_CC_V] = sh_v;
              cc_d[CDOALU_CC_C] = sh_c;
            end
            CDOALU_OP_DIV: begin
              // Odd or stack register destinations are left to the caller
              if (src_in == 16'h0000) begin
                cc_d[CDOALU_CC_V] = 1'b1;
                cc_d[CDOALU_CC_C] = 1'b1;
              end else begin
                done_d = 1'b0;
                st_d = CDOALU_DIVW;
              end
            end
            default: begin
              // Unknown code answers with flags untouched, except octal 007, which gets N clear and Z set
              cc_d = cc_in;
            end
          endcase
          // Logic and copy flags follow the operand width
          if (op_in[5:0] <= 6'o16 && op_in[6] == 1'b0 &&
              op_in != CDOALU_OP_ADD_W && op_in != CDOALU_OP_SUB_W &&
              op_in[2:0] != 3'h0) begin
            cc_d[CDOALU_CC_N] = byte_op ? r[7] : r[15];
            cc_d[CDOALU_CC_Z] = byte_op ? (r[7:0] == 8'h00) :
                                (r == 16'h0000);
          end else if (op_in == CDOALU_OP_ADD_W ||
                       op_in == CDOALU_OP_SUB_W ||
                       op_in == CDOALU_OP_XOR) begin
            cc_d[CDOALU_CC_N] = r[15];
            cc_d[CDOALU_CC_Z] = (r == 16'h0000);
          end
          ccin_d = cc_in;
          op_d = op_in;
          idx_d = reg_idx_in;
          divsr_d = src_in;
        end
      end
      CDOALU_DIVW: begin
        if (div_done) begin
          st_d = CDOALU_DONE;
          done_d = 1'b1;
          rres_d = quot[15:0];
          pres_d = rem[15:0];
          wr_reg_d = 1'b1;
          wr_pair_d = 1'b1;
          cc_d = ccin_q;
          cc_d[CDOALU_CC_N] = quot[15];
          cc_d[CDOALU_CC_Z] = (quot[15:0] == 16'h0000);
          cc_d[CDOALU_CC_V] = (quot[31:15] != {17{quot[31]}});
          cc_d[CDOALU_CC_C] = 1'b0;
        end
      end
      CDOALU_DONE: begin
        st_d = CDOALU_IDLE;
      end
      default: begin
        st_d = CDOALU_IDLE;
      end
    endcase
  end

  // --------------------
  // State and output registers
  // --------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= CDOALU_IDLE;
      op_q <= 7'h00;
      idx_q <= 3'h0;
      ccin_q <= CDOALU_CC_RST;
      divsr_q <= CDOALU_WORD_RST;
      done_q <= 1'b0;
      wr_dst_q <= 1'b0;
      wr_reg_q <= 1'b0;
      wr_pair_q <= 1'b0;
      dres_q <= CDOALU_WORD_RST;
      rres_q <= CDOALU_WORD_RST;
      pres_q <= CDOALU_WORD_RST;
      ridx_q <= 3'h0;
      pidx_q <= 3'h0;
      cc_q <= CDOALU_CC_RST;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      ccin_q <= ccin_d;
      divsr_q <= divsr_d;
      done_q <= done_d;
      wr_dst_q <= wr_dst_d;
      wr_reg_q <= wr_reg_d;
      wr_pair_q <= wr_pair_d;
      dres_q <= dres_d;
      rres_q <= rres_d;
      pres_q <= pres_d;
      ridx_q <= ridx_d;
      pidx_q <= pidx_d;
      cc_q <= cc_d;
    end
  end

  // Busy covers the divide wait; a one-hot code keeps it a single flop read
  assign busy_out = st_q[1];
  assign done_out = done_q;
  assign wr_dst_out = wr_dst_q;
  assign dst_res_out = dres_q;
  assign wr_reg_out = wr_reg_q;
  assign reg_idx_out = ridx_q;
  assign reg_res_out = rres_q;
  assign wr_pair_out = wr_pair_q;
  assign pair_idx_out = pidx_q;
  assign pair_res_out = pres_q;
  assign cc_out = cc_q;

endmodule : cdoalu_core

/* verilog/cdoalu_div.sv */
// Sequential signed restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module cdoalu_div (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Request
  input wire logic start_in,
  input wire logic [31:0] dividend_in,
  input wire logic [15:0] divisor_in,
  // Answer
  output logic done_out,
  output logic [31:0] quot_out,
  output logic [31:0] rem_out
);
  import cdoalu_pkg::*;

  // --------------------
  // Iteration state
  // --------------------
  logic [31:0] q_q, q_d;
  logic [32:0] r_q, r_d;
  logic [31:0] dv_q, dv_d;
  logic [5:0] cnt_q, cnt_d;
  logic nq_q, nq_d, nr_q, nr_d, busy_q, busy_d, done_q, done_d;
  logic [32:0] trial;

  // Magnitudes divided, signs restored at the end (remainder takes dividend)
  always_comb begin
    q_d = q_q;
    r_d = r_q;
    dv_d = dv_q;
    cnt_d = cnt_q;
    nq_d = nq_q;
    nr_d = nr_q;
    busy_d = busy_q;
    done_d = 1'b0;
    trial = {r_q[31:0], q_q[31]} - {1'b0, dv_q};
    if (start_in && !busy_q) begin
      q_d = dividend_in[31] ? 32'(-dividend_in) : dividend_in;
      dv_d = divisor_in[15] ? 32'(-{{16{divisor_in[15]}}, divisor_in})
                            : {16'h0000, divisor_in};
      r_d = 33'h0;
      nr_d = dividend_in[31];
      nq_d = dividend_in[31] ^ divisor_in[15];
      cnt_d = CDOALU_DIV_STEPS;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (trial[32]) begin
        r_d = {r_q[31:0], q_q[31]};
        q_d = {q_q[30:0], 1'b0};
      end else begin
        r_d = trial;
        q_d = {q_q[30:0], 1'b1};
      end
      cnt_d = cnt_q - 6'h01;
      if (cnt_q == 6'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Register the iteration state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_q <= 32'h0;
      r_q <= 33'h0;
      dv_q <= 32'h0;
      cnt_q <= 6'h00;
      nq_q <= 1'b0;
      nr_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      q_q <= q_d;
      r_q <= r_d;
      dv_q <= dv_d;
      cnt_q <= cnt_d;
      nq_q <= nq_d;
      nr_q <= nr_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;
  assign quot_out = nq_q ? 32'(-q_q) : q_q;
  assign rem_out = nr_q ? 32'(-r_q[31:0]) : r_q[31:0];

endmodule : cdoalu_div

/* verilog/cdoalu_shift.sv */
// Combinational arithmetic shifter for single and paired register shifts
`timescale 1ns/1ps
module cdoalu_shift (
  // Operands
  input wire logic [31:0] val_in,
  input wire logic [5:0] count_in,
  input wire logic pair_in,
  // Results
  output logic [31:0] res_out,
  output logic carry_out,
  output logic ovf_out
);
  import cdoalu_pkg::*;

  // --------------------
  // Shift datapath
  // --------------------
  logic [63:0] ext;
  logic [63:0] wide;
  logic [5:0] mag;
  logic sgn;
  int unsigned top;

  // Work in a 64-bit field so counts of 32 still yield the last bit out
  always_comb begin
    top = pair_in ? 31 : 15;
    sgn = val_in[top];
    ext = pair_in ? {{32{val_in[31]}}, val_in} :
                    {{48{val_in[15]}}, val_in[15:0]};
    mag = count_in[5] ? 6'(-count_in) : count_in;
    wide = 64'h0;
    carry_out = 1'b0;
    ovf_out = 1'b0;
    res_out = 32'h0;
    if (count_in == 6'h00) begin
      res_out = val_in;
    end else if (count_in[5]) begin
      // Right: sign fills from the top
      wide = $signed(ext) >>> mag;
      carry_out = ext[mag - 6'h01];
      res_out = pair_in ? wide[31:0] : {16'h0000, wide[15:0]};
    end else begin
      wide = ext << mag;
      carry_out = wide[top + 1];
      res_out = pair_in ? wide[31:0] : {16'h0000, wide[15:0]};
      // Any bit passing through the sign slot that differs trips overflow
      for (int i = 0; i <= 31; i++) begin
        if ((i <= int'(mag)) && (i <= int'(top)) &&
            (val_in[top - i] != sgn)) begin
          ovf_out = 1'b1;
        end
      end
    end
  end

endmodule : cdoalu_shift
